/* include/sfd_defs.vh */
// Purpose: Constants of the slow/fast processor clock divider.
// Assumes: Every clk_sys edge is one transition of the clock source.
// Notes:   Counts are in clk_sys cycles unless the name says pulses.
`ifndef SFD_DEFS_VH
`define SFD_DEFS_VH

// Rate of the system clock in hertz.
`define SFD_CLK_HZ           20000000
// Clock edges that make up one source pulse.
`define SFD_EDGES_PER_SRC    2
// Source divisors of the processor clocks and the peripheral clock.
`define SFD_FAST_DIV         3
`define SFD_SLOW_DIV         768
`define SFD_PCLK_DIV         6
// Edges in one divided processor period, and edges spent high.
`define SFD_DIV3_STEPS       (`SFD_FAST_DIV * `SFD_EDGES_PER_SRC)
`define SFD_CPU_HIGH_STEPS   2
`define SFD_HALF_HIGH_STEPS  3
// Slow prescale factor, from the ratio of the two divisors.
`define SFD_SLOW_PRESCALE    (`SFD_SLOW_DIV / `SFD_FAST_DIV)
`define SFD_PRE_LAST         8'hFF
// Peripheral clock period in edges and its last phase.
`define SFD_PCLK_STEPS       (`SFD_PCLK_DIV * `SFD_EDGES_PER_SRC)
`define SFD_PCLK_LAST        4'hB
`define SFD_PCLK_HALF        4'h6
// Least lengths of the speed select levels in source pulses.
`define SFD_SLOW_MIN_PULSES  195
`define SFD_FAST_MIN_PULSES  3
// The same lengths in clock cycles.
`define SFD_SLOW_MIN_CYC     (`SFD_SLOW_MIN_PULSES * `SFD_EDGES_PER_SRC)
`define SFD_FAST_MIN_CYC     (`SFD_FAST_MIN_PULSES * `SFD_EDGES_PER_SRC)
// Reset values.
`define SFD_RST_FAST         1'b1
`define SFD_RST_RUN          1'b1

`endif

/* design/sfd_sync3.v */
// Purpose: Three-stage synchroniser for one pin input.
// Assumes: The pin is asynchronous to clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module sfd_sync3 (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Pin and synchronised stages
  input  wire pin_in,
  output reg  stage2_r,
  output reg  stage3_r
);

  reg meta_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

endmodule

`default_nettype wire

/* design/sfd_div3.v */
// Purpose: Divide-by-three step counter with a registered waveform.
// Assumes: One period is six clock edges, advanced by adv.
// Notes:   The waveform is high in the last HIGH_N steps, so it falls on wrap.
`timescale 1ns/1ps
`default_nettype none

`include "sfd_defs.vh"

module sfd_div3 #(
  parameter [2:0] HIGH_N = 3'h2
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Step control
  input  wire       adv,
  // Count and waveform
  output reg  [2:0] cnt_r,
  output reg        wave_r
);

  localparam [2:0] LAST = `SFD_DIV3_STEPS - 1;
  localparam [2:0] RISE = `SFD_DIV3_STEPS - HIGH_N;

  reg [2:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (adv) begin
      cnt_nxt = (cnt_r == LAST) ? 3'h0 : cnt_r + 3'h1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 3'h0;
      wave_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      wave_r <= (cnt_nxt >= RISE);
    end
  end

endmodule

`default_nettype wire

/* design/sfd_clock_divider.v */
// Purpose: Slow/fast speed selection of the processor clocks.
// Assumes: clk_sys is the running source; speed, stop and start are pins.
// Notes:   All outputs are flip-flops; the source keeps full rate throughout.
`timescale 1ns/1ps
`default_nettype none

`include "sfd_defs.vh"

// Operation
// - Speed select high divides by 3, low 768.
// - Stop handling is identical in both modes.
// - Peripheral clock rate ignores speed select.
// - Slow needs 195 low source pulses first.
// - Fast needs speed select high 3 pulses.
// - Fast division starts at next peripheral edge without a slow step.
// - Switching keeps phase and minimum pulse widths.
// - Slow switch acts on next peripheral edge, fast on next without a slow step.
// - Oscillator keeps full rate in slow mode.
// - Buffered oscillator copy is driven out.
// - Peripheral clock is source over 6, 50%.
// - Processor clocks 33% and 50%, common fall.
// - Peripheral falls align with processor clock falls in fast mode.
module sfd_clock_divider (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Control pins
  input  wire speed_select,
  input  wire stop_request,
  input  wire start_request,
  // Clock outputs
  output reg  buffered_oscillator_output,
  output reg  peripheral_clock,
  output wire cpu_clock,
  output wire half_duty_clock,
  // Status
  output reg  fast_mode_r,
  output reg  running_r
);

  localparam [8:0] SLOW_CYC = `SFD_SLOW_MIN_CYC;
  localparam [8:0] FAST_CYC = `SFD_FAST_MIN_CYC;
  localparam [2:0] CPU_LAST = `SFD_DIV3_STEPS - 1;

  wire       sel_s2;
  wire       sel_s3;
  wire       stop_s2;
  wire       stop_s3;
  wire       start_s2;
  wire       start_s3;
  wire [2:0] cpu_cnt;

  reg        req_fast_r;
  reg        req_fast_nxt;
  reg  [8:0] deb_cnt_r;
  reg  [8:0] deb_cnt_nxt;
  reg  [7:0] pre_r;
  reg  [3:0] ph_r;
  reg  [3:0] ph_nxt;
  reg        stop_pend_r;
  reg        adv;
  reg        adv_raw;
  reg        freeze;
  reg        in_step;
  reg        mode_load;
  reg        pclk_edge;

  // Peripheral phase folded onto one processor period.
  function [3:0] fold6;
    input [3:0] ph;
    begin
      if (ph >= `SFD_PCLK_HALF) begin
        fold6 = ph - `SFD_PCLK_HALF;
      end else begin
        fold6 = ph;
      end
    end
  endfunction

  // Pin synchronisers.
  sfd_sync3 u_sel (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (speed_select),
    .stage2_r (sel_s2),
    .stage3_r (sel_s3)
  );

  sfd_sync3 u_stop (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (stop_request),
    .stage2_r (stop_s2),
    .stage3_r (stop_s3)
  );

  sfd_sync3 u_start (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (start_request),
    .stage2_r (start_s2),
    .stage3_r (start_s3)
  );

  // Debounce of the speed select level against the recognised request.
  always @* begin
    req_fast_nxt = req_fast_r;
    deb_cnt_nxt  = 9'h000;
    if ((sel_s2 == sel_s3) && (sel_s3 != req_fast_r)) begin
      deb_cnt_nxt = deb_cnt_r + 9'h001;
      if (sel_s3 && (deb_cnt_nxt >= FAST_CYC)) begin
        req_fast_nxt = 1'b1;
        deb_cnt_nxt  = 9'h000;
      end else if (!sel_s3 && (deb_cnt_nxt >= SLOW_CYC)) begin
        req_fast_nxt = 1'b0;
        deb_cnt_nxt  = 9'h000;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_fast_r <= `SFD_RST_FAST;
      deb_cnt_r  <= 9'h000;
    end else begin
      req_fast_r <= req_fast_nxt;
      deb_cnt_r  <= deb_cnt_nxt;
    end
  end

  // Step request: every edge when fast, 1 in 256 when slow.
  always @* begin
    adv_raw = running_r && (fast_mode_r || (pre_r == `SFD_PRE_LAST));
  end

  // A pending stop pauses all clock counters, not the debounce, on the step that would leave step 5.
  always @* begin
    freeze = stop_pend_r && (cpu_cnt == CPU_LAST) && adv_raw;
  end

  // Fast steps wait until the processor count matches the peripheral phase.
  always @* begin
    in_step = ({1'b0, cpu_cnt} == fold6(ph_r));
  end

  // Waiting only lengthens a level, so no pulse gets shorter.
  always @* begin
    adv = adv_raw && !freeze;
    if (fast_mode_r && !in_step) begin
      adv = 1'b0;
    end
  end

  // Peripheral clock phase, independent of the speed mode.
  always @* begin
    ph_nxt = ph_r;
    if (running_r && !freeze) begin
      ph_nxt = (ph_r == `SFD_PCLK_LAST) ? 4'h0 : ph_r + 4'h1;
    end
    pclk_edge = running_r && !freeze &&
                ((ph_nxt == 4'h0) || (ph_nxt == `SFD_PCLK_HALF));
  end

  // A slow step on a peripheral edge defers the mode change by one edge.
  always @* begin
    mode_load = pclk_edge && !(adv && !fast_mode_r);
  end

  // Buffered copy of the source, never stopped.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buffered_oscillator_output <= 1'b0;
    end else begin
      buffered_oscillator_output <= ~buffered_oscillator_output;
    end
  end

  // Peripheral clock phase and waveform.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_r             <= 4'h0;
      peripheral_clock <= 1'b0;
    end else begin
      ph_r             <= ph_nxt;
      peripheral_clock <= (ph_nxt >= `SFD_PCLK_HALF);
    end
  end

  // Slow prescaler, held while the clocks are stopped.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 8'h00;
    end else begin
      if (fast_mode_r) begin
        pre_r <= 8'h00;
      end else if (running_r && !freeze) begin
        pre_r <= pre_r + 8'h01;
      end
    end
  end

  // Applied speed mode, changed only on a peripheral clock edge.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_mode_r <= `SFD_RST_FAST;
    end else begin
      if (mode_load) begin
        fast_mode_r <= req_fast_r;
      end
    end
  end

  // Stop holds the processor clocks high and the peripheral clock in place.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_pend_r <= 1'b0;
      running_r   <= `SFD_RST_RUN;
    end else begin
      if (start_s2 && start_s3) begin
        stop_pend_r <= 1'b0;
        running_r   <= 1'b1;
      end else if (stop_s2 && stop_s3 && running_r) begin
        stop_pend_r <= 1'b1;
      end
      if (freeze && !(start_s2 && start_s3)) begin
        running_r <= 1'b0;
      end
    end
  end

  // Two divide-by-three counters sharing one enable keep their phase.
  sfd_div3 #(
    .HIGH_N (`SFD_CPU_HIGH_STEPS)
  ) u_cpu (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .adv     (adv),
    .cnt_r   (cpu_cnt),
    .wave_r  (cpu_clock)
  );

  sfd_div3 #(
    .HIGH_N (`SFD_HALF_HIGH_STEPS)
  ) u_half (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .adv     (adv),
    .cnt_r   (),
    .wave_r  (half_duty_clock)
  );

endmodule

`default_nettype wire

/* verification/sfd_monitor.sv */
// Purpose: Port assertions of the clock divider.
// Assumes: Speed select is held steady while clocks are stopped.
// Notes:   A counter tracks how long speed select has held its level.
`timescale 1ns/1ps
`default_nettype none
module sfd_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Pins
  input wire speed_select,
  input wire stop_request,
  input wire start_request,
  // Outputs
  input wire buffered_oscillator_output,
  input wire peripheral_clock,
  input wire cpu_clock,
  input wire half_duty_clock,
  input wire fast_mode_r,
  input wire running_r
);
  reg        sel_d_r;
  reg [15:0] run_cnt_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_d_r   <= 1'b1;
      run_cnt_r <= 16'h0000;
    end else begin
      sel_d_r <= speed_select;
      if (speed_select != sel_d_r)
        run_cnt_r <= 16'h0000;
      else if (run_cnt_r != 16'hFFFF)
        run_cnt_r <= run_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_osc_toggle: assert property (
    $past(rst_n) |-> $changed(buffered_oscillator_output))
    else $error("oscillator copy missed a toggle");
  a_fall_common: assert property (
    $fell(cpu_clock) |-> $fell(half_duty_clock))
    else $error("processor clocks fell apart");
  a_cpu_high: assert property (
    $rose(cpu_clock) ##0 (fast_mode_r && running_r)[*3] |-> !cpu_clock)
    else $error("fast cpu clock high width wrong");
  a_half_high: assert property (
    $rose(half_duty_clock) ##0 (fast_mode_r && running_r)[*4]
    |-> !half_duty_clock)
    else $error("fast half duty clock high width wrong");
  a_pclk_high: assert property (
    $rose(peripheral_clock) ##0 running_r[*7] |-> $fell(peripheral_clock))
    else $error("peripheral clock high width wrong");
  a_pclk_edge: assert property (
    $fell(cpu_clock) |-> $changed(peripheral_clock))
    else $error("cpu clock fell off a peripheral edge");
  a_mode_edge: assert property (
    $changed(fast_mode_r) |-> $changed(peripheral_clock))
    else $error("mode changed off a peripheral edge");
  a_slow_hold: assert property (
    $fell(fast_mode_r) |-> run_cnt_r >= 16'h0186)
    else $error("slow mode taken on a short low level");
  a_fast_hold: assert property (
    $rose(fast_mode_r) |-> speed_select && run_cnt_r >= 16'h0006)
    else $error("fast mode taken on a short high level");
  a_fast_late: assert property (
    running_r && speed_select && run_cnt_r == 16'h0014 |-> fast_mode_r)
    else $error("fast mode came late");
  a_slow_late: assert property (
    running_r && !speed_select && run_cnt_r == 16'h019A |-> !fast_mode_r)
    else $error("slow mode came late");
endmodule
bind sfd_clock_divider sfd_monitor mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .speed_select(speed_select),
  .stop_request(stop_request), .start_request(start_request),
  .buffered_oscillator_output(buffered_oscillator_output),
  .peripheral_clock(peripheral_clock), .cpu_clock(cpu_clock),
  .half_duty_clock(half_duty_clock), .fast_mode_r(fast_mode_r),
  .running_r(running_r));
`default_nettype wire

/* verification/sfd_cpu_model.sv */
// Purpose: Processor side that measures the clocks it receives.
// Assumes: Periods are counted in clk_sys cycles between rising edges.
// Notes:   Periods read zero until the first rising edge, which loads the count from time zero.
`timescale 1ns/1ps
`default_nettype none
module sfd_cpu_model (
  // Clock
  input  wire        clk_sys,
  // Received clocks
  input  wire        cpu_clock,
  input  wire        peripheral_clock,
  // Measured periods
  output reg  [15:0] cpu_per,
  output reg  [15:0] pclk_per
);
  reg [15:0] cpu_cnt = 16'h0000;
  reg [15:0] pclk_cnt = 16'h0000;
  reg        cpu_d = 1'b0;
  reg        pclk_d = 1'b0;
  initial cpu_per = 16'h0000;
  initial pclk_per = 16'h0000;
  always @(posedge clk_sys) begin
    cpu_d <= cpu_clock;
    pclk_d <= peripheral_clock;
    cpu_cnt <= (cpu_clock && !cpu_d) ? 16'h0001 : cpu_cnt + 16'h0001;
    pclk_cnt <= (peripheral_clock && !pclk_d) ? 16'h0001 : pclk_cnt + 16'h0001;
    if (cpu_clock && !cpu_d)
      cpu_per <= cpu_cnt;
    if (peripheral_clock && !pclk_d)
      pclk_per <= pclk_cnt;
  end
endmodule
`default_nettype wire

/* verification/slow_fast_clock_divider_tb.sv */
// Purpose: Self-checking bench of the slow/fast clock divider.
// Assumes: Source is clk_sys/2, so periods are 6, 1536 and 12 cycles.
// Notes:   Speed select is never changed while clocks are stopped.
`timescale 1ns/1ps
`default_nettype none
module slow_fast_clock_divider_tb;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         speed_select = 1'b1;
  reg         stop_request = 1'b0;
  reg         start_request = 1'b0;
  wire        osc_out;
  wire        pclk;
  wire        cpu_clk;
  wire        half_clk;
  wire        fast_mode;
  wire        running;
  wire [15:0] cpu_per;
  wire [15:0] pclk_per;
  integer     error_cnt = 0;
  integer     compares = 0;
  integer     cycles = 0;
  always #25 clk_sys = ~clk_sys;
  sfd_clock_divider uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .speed_select(speed_select), .stop_request(stop_request),
    .start_request(start_request), .buffered_oscillator_output(osc_out),
    .peripheral_clock(pclk), .cpu_clock(cpu_clk),
    .half_duty_clock(half_clk), .fast_mode_r(fast_mode),
    .running_r(running));
  sfd_cpu_model cpu (.clk_sys(clk_sys), .cpu_clock(cpu_clk),
    .peripheral_clock(pclk), .cpu_per(cpu_per), .pclk_per(pclk_per));
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #5;
    end
  endtask
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
      end
    end
  endtask
  task rates(input m, input [15:0] per);
    begin
      chk("mode", {15'h0000, fast_mode}, {15'h0000, m});
      chk("cpu period", cpu_per, per);
      chk("pclk period", pclk_per, 16'h000C);
    end
  endtask
  task t_stop;
    integer i;
    begin
      stop_request = 1'b1;
      for (i = 0; i < 2000 && running; i = i + 1)
        cyc(1);
      chk("running", {15'h0000, running}, 16'h0000);
      chk("stopped cpu", {14'h0000, cpu_clk, half_clk}, 16'h0003);
      stop_request = 1'b0;
      start_request = 1'b1;
      cyc(5);
      chk("restarted", {15'h0000, running}, 16'h0001);
      start_request = 1'b0;
      $display("Test stop done");
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 12000) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(40);
    rates(1'b1, 16'h0006);
    $display("Test fast done");
    speed_select = 1'b0;
    cyc(300);
    speed_select = 1'b1;
    cyc(20);
    rates(1'b1, 16'h0006);
    $display("Test glitch done");
    speed_select = 1'b0;
    cyc(3600);
    rates(1'b0, 16'h0600);
    $display("Test slow done");
    t_stop;
    speed_select = 1'b1;
    cyc(60);
    rates(1'b1, 16'h0006);
    $display("Test back to fast done");
    t_stop;
    end_of_test;
  end
endmodule
`default_nettype wire
